/* rtl/fcmi_bus_if.sv */
// interface: one flash bus cycle between sequencer and pin driver
`timescale 1ns/1ps
interface fcmi_bus_if;
  logic start;
  logic wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output start, output wr, output addr, output wdata, input done, input rdata);
  modport pin (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* rtl/fcmi_cycle.sv */
// one asynchronous flash bus cycle: strobes, data drive and read capture
`timescale 1ns/1ps
module fcmi_cycle
  import fcmi_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  fcmi_bus_if.pin bus,
  output logic [FCMI_ADDR_W-1:0] addr_out,
  output logic [FCMI_DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic [FCMI_DATA_W-1:0] dq_in,
  output logic we_n_out,
  output logic oe_n_out,
  output logic ce_n_out
);
  typedef enum logic [1:0] {
    FCMI_CY_IDLE = 2'h0,
    FCMI_CY_STROBE = 2'h1,
    FCMI_CY_DONE = 2'h2
  } fcmi_cy_t;
  fcmi_cy_t st_reg, st_next;
  logic [FCMI_CNT_W-1:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic [FCMI_ADDR_W-1:0] a_reg, a_next;
  logic [FCMI_DATA_W-1:0] d_reg, d_next, rd_reg, rd_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    a_next = a_reg;
    d_next = d_reg;
    rd_next = rd_reg;
    case (st_reg)
      FCMI_CY_IDLE: begin
        if (bus.start) begin
          st_next = FCMI_CY_STROBE;
          wr_next = bus.wr;
          a_next = bus.addr;
          d_next = bus.wdata;
          cnt_next = bus.wr ? FCMI_CNT_W'(FCMI_WP_CYC) : FCMI_CNT_W'(FCMI_RC_CYC);
        end
      end
      FCMI_CY_STROBE: begin
        if (cnt_reg <= 4'h1) begin
          st_next = FCMI_CY_DONE;
          rd_next = dq_in;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      FCMI_CY_DONE: st_next = FCMI_CY_IDLE;
      default: st_next = FCMI_CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_reg <= FCMI_CY_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      a_reg <= '0;
      d_reg <= '0;
      rd_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      a_reg <= a_next;
      d_reg <= d_next;
      rd_reg <= rd_next;
    end
  end

  // write data latches on rising we_n at the end of the strobe phase;
  // ce_n stays low through done so it never rises together with we_n
  assign addr_out = a_reg;
  assign dq_out = d_reg;
  assign dq_oe_out = wr_reg && (st_reg != FCMI_CY_IDLE);
  assign we_n_out = !(wr_reg && st_reg == FCMI_CY_STROBE);
  assign oe_n_out = !(!wr_reg && st_reg == FCMI_CY_STROBE);
  assign ce_n_out = (st_reg == FCMI_CY_IDLE);
  assign bus.done = (st_reg == FCMI_CY_DONE);
  assign bus.rdata = rd_reg;

  a_strobe_one_dir: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !(!we_n_out && !oe_n_out)) else $error("write and read strobes both active");
endmodule

/* rtl/fcmi_host.sv */
// top: host sequencer that issues guarded command sequences to the flash
`timescale 1ns/1ps
// Overview of operation
// - program always sent after two unlock writes, never alone
// - erase always sent as full six-write sequence
// - query entry by unlock pair then 98H at bank word 555H
// - query entry also by single 98H write at bank word 55H
// - query mode held until host sends exit command
// - user part written only by its own area program command
// - area program completion found by toggling bit, not complement bit
// - id area query by three writes ending 88H at 555H; left by exit
module fcmi_host
  import fcmi_pkg::*;
#(
  parameter int ADDR_W = FCMI_ADDR_W
)(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [2:0] req_op_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [FCMI_DATA_W-1:0] req_data_in,
  input wire logic [7:0] req_sub_in,
  output logic rsp_valid_out,
  output logic [FCMI_DATA_W-1:0] rsp_data_out,
  output logic rsp_busy_out,
  output logic [2:0] mode_out,
  output logic [2:0] mode_bank_out,
  output logic area_locked_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [FCMI_DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic [FCMI_DATA_W-1:0] dq_in,
  output logic we_n_out,
  output logic oe_n_out,
  output logic ce_n_out,
  input wire logic ready_in
);
  initial begin
    if (ADDR_W != FCMI_ADDR_W) $error("address width must match the flash map");
  end

  typedef enum logic [2:0] {
    FCMI_ST_IDLE = 3'h0,
    FCMI_ST_ISSUE = 3'h1,
    FCMI_ST_WAIT = 3'h2,
    FCMI_ST_POLL = 3'h3,
    FCMI_ST_POLL_WAIT = 3'h4,
    FCMI_ST_RESP = 3'h5
  } fcmi_st_t;

  fcmi_bus_if bus ();

  fcmi_st_t st_reg, st_next;
  fcmi_op_t op_reg, op_next;
  logic [2:0] step_reg, step_next;
  logic [2:0] nsteps_reg, nsteps_next;
  logic [ADDR_W-1:0] a_reg, a_next;
  logic [FCMI_DATA_W-1:0] d_reg, d_next;
  logic [7:0] sub_reg, sub_next;
  logic [FCMI_DATA_W-1:0] rsp_reg, rsp_next;
  logic [FCMI_DATA_W-1:0] last_reg, last_next;
  logic first_poll_reg, first_poll_next;
  fcmi_mode_t mode_reg, mode_next;
  logic [2:0] bank_reg, bank_next;
  logic locked_reg, locked_next;
  logic [ADDR_W-1:0] wa;
  logic [FCMI_DATA_W-1:0] wd;

  // bank-relative command address: bank bits from the target, offset given
  function automatic logic [ADDR_W-1:0] bank_addr(input logic [ADDR_W-1:0] tgt,
                                                  input logic [ADDR_W-1:0] off);
    bank_addr = {tgt[ADDR_W-1:FCMI_BANK_LSB], off[FCMI_BANK_LSB-1:0]};
  endfunction

  // command byte sent in low lane, upper lane driven zero
  function automatic logic [FCMI_DATA_W-1:0] cmd(input logic [7:0] c);
    cmd = {8'h00, c};
  endfunction

  // step table: write address and data for each write of a sequence
  always_comb begin
    wa = bank_addr(a_reg, FCMI_UNLOCK_A1);
    wd = cmd(FCMI_UNLOCK_D1);
    // unlock pair precedes every guarded command
    if (step_reg == 3'h1 || step_reg == 3'h4) begin
      wa = bank_addr(a_reg, FCMI_UNLOCK_A2);
      wd = cmd(FCMI_UNLOCK_D2);
    end else if (step_reg == 3'h2) begin
      case (op_reg)
        FCMI_OP_PROG: wd = cmd(FCMI_CMD_PROG);
        // erase setup then second unlock pair and erase code
        FCMI_OP_ERASE: wd = cmd(FCMI_CMD_ERASE);
        FCMI_OP_ID: wd = cmd(FCMI_CMD_ID_ENTRY);
        // long query entry at bank word 555H
        FCMI_OP_QUERY: wd = cmd(FCMI_CMD_QUERY);
        // id area query ends with 88H at 555H
        FCMI_OP_AREA: wd = cmd(FCMI_CMD_AREA_QUERY);
        // user area only via its own program code
        FCMI_OP_AREA_PROG: wd = (sub_reg == FCMI_CMD_AREA_LOCK) ? cmd(FCMI_CMD_AREA_LOCK)
                                                               : cmd(FCMI_CMD_AREA_PROG);
        default: wd = cmd(FCMI_CMD_EXIT);
      endcase
    end else if (step_reg == 3'h3 && op_reg != FCMI_OP_ERASE) begin
      wa = a_reg;
      wd = d_reg;
    end else if (step_reg == 3'h5) begin
      wa = (sub_reg == FCMI_CMD_ERASE_CHIP) ? FCMI_UNLOCK_A1 : a_reg;
      wd = cmd(sub_reg);
    end
    // short query entry is one write of 98H at bank word 55H
    if (op_reg == FCMI_OP_QUERY && nsteps_reg == 3'h1) begin
      wa = bank_addr(a_reg, FCMI_QUERY_SHORT_A);
      wd = cmd(FCMI_CMD_QUERY);
    end
    // exit is a single write of the exit code
    if (op_reg == FCMI_OP_EXIT) begin
      wa = a_reg;
      wd = cmd(FCMI_CMD_EXIT);
    end
  end

  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    step_next = step_reg;
    nsteps_next = nsteps_reg;
    a_next = a_reg;
    d_next = d_reg;
    sub_next = sub_reg;
    rsp_next = rsp_reg;
    last_next = last_reg;
    first_poll_next = first_poll_reg;
    mode_next = mode_reg;
    bank_next = bank_reg;
    locked_next = locked_reg;
    bus.start = 1'b0;
    bus.wr = 1'b1;
    bus.addr = wa;
    bus.wdata = wd;
    case (st_reg)
      FCMI_ST_IDLE: begin
        if (req_valid_in) begin
          op_next = fcmi_op_t'(req_op_in);
          a_next = req_addr_in;
          d_next = req_data_in;
          sub_next = req_sub_in;
          step_next = 3'h0;
          st_next = FCMI_ST_ISSUE;
          case (fcmi_op_t'(req_op_in))
            FCMI_OP_READ: nsteps_next = 3'h0;
            FCMI_OP_ERASE: nsteps_next = 3'h6;
            FCMI_OP_PROG: nsteps_next = 3'h4;
            FCMI_OP_AREA_PROG: nsteps_next = (req_sub_in == FCMI_CMD_AREA_LOCK) ? 3'h4 : 3'h4;
            FCMI_OP_QUERY: nsteps_next = (req_sub_in == FCMI_CMD_QUERY) ? 3'h1 : 3'h3;
            FCMI_OP_EXIT: nsteps_next = 3'h1;
            default: nsteps_next = 3'h3;
          endcase
          // programs into a locked user area are refused here
          if (fcmi_op_t'(req_op_in) == FCMI_OP_AREA_PROG && locked_reg) begin
            st_next = FCMI_ST_RESP;
            rsp_next = 16'hFFFF;
          end
          // no exit while an internal operation still runs
          if (fcmi_op_t'(req_op_in) == FCMI_OP_EXIT && !ready_in) begin
            st_next = FCMI_ST_RESP;
            rsp_next = 16'hFFFF;
          end
        end
      end
      FCMI_ST_ISSUE: begin
        bus.start = 1'b1;
        bus.wr = (step_reg < nsteps_reg);
        if (!bus.wr) begin
          bus.addr = a_reg;
        end
        st_next = FCMI_ST_WAIT;
      end
      FCMI_ST_WAIT: begin
        if (bus.done) begin
          if (step_reg < nsteps_reg) begin
            step_next = step_reg + 3'h1;
            if (step_reg + 3'h1 == nsteps_reg) begin
              if (op_reg == FCMI_OP_PROG || op_reg == FCMI_OP_ERASE ||
                  op_reg == FCMI_OP_AREA_PROG) begin
                st_next = FCMI_ST_POLL;
                first_poll_next = 1'b1;
              end else if (op_reg == FCMI_OP_READ) begin
                st_next = FCMI_ST_ISSUE;
              end else begin
                st_next = FCMI_ST_RESP;
                // mode applies only to the targeted bank
                bank_next = a_reg[FCMI_BANK_LSB +: 3];
                case (op_reg)
                  FCMI_OP_ID: mode_next = FCMI_MODE_ID;
                  // query mode held until an exit
                  FCMI_OP_QUERY: mode_next = FCMI_MODE_QUERY;
                  FCMI_OP_AREA: mode_next = FCMI_MODE_AREA;
                  default: mode_next = FCMI_MODE_ARRAY;
                endcase
              end
            end else begin
              st_next = FCMI_ST_ISSUE;
            end
          end else begin
            rsp_next = bus.rdata;
            st_next = FCMI_ST_RESP;
          end
        end
      end
      FCMI_ST_POLL: begin
        // completion seen by the toggling bit only
        bus.start = 1'b1;
        bus.wr = 1'b0;
        bus.addr = a_reg;
        st_next = FCMI_ST_POLL_WAIT;
      end
      FCMI_ST_POLL_WAIT: begin
        if (bus.done) begin
          last_next = bus.rdata;
          // two equal toggling bits in a row mean the operation ended
          if (!first_poll_reg && bus.rdata[FCMI_TOGGLE_BIT[3:0]] ==
              last_reg[FCMI_TOGGLE_BIT[3:0]]) begin
            rsp_next = bus.rdata;
            st_next = FCMI_ST_RESP;
            if (op_reg == FCMI_OP_AREA_PROG && sub_reg == FCMI_CMD_AREA_LOCK) begin
              locked_next = 1'b1;
            end
          end else begin
            st_next = FCMI_ST_POLL;
          end
          first_poll_next = 1'b0;
        end
      end
      FCMI_ST_RESP: st_next = FCMI_ST_IDLE;
      default: st_next = FCMI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_reg <= FCMI_ST_IDLE;
      op_reg <= FCMI_OP_READ;
      step_reg <= 3'h0;
      nsteps_reg <= 3'h0;
      a_reg <= '0;
      d_reg <= '0;
      sub_reg <= 8'h00;
      rsp_reg <= '0;
      last_reg <= '0;
      first_poll_reg <= 1'b0;
      mode_reg <= FCMI_MODE_ARRAY;
      bank_reg <= 3'h0;
      locked_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      step_reg <= step_next;
      nsteps_reg <= nsteps_next;
      a_reg <= a_next;
      d_reg <= d_next;
      sub_reg <= sub_next;
      rsp_reg <= rsp_next;
      last_reg <= last_next;
      first_poll_reg <= first_poll_next;
      mode_reg <= mode_next;
      bank_reg <= bank_next;
      locked_reg <= locked_next;
    end
  end

  fcmi_cycle u_cycle (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .bus(bus.pin),
    .addr_out(addr_out),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out),
    .dq_in(dq_in),
    .we_n_out(we_n_out),
    .oe_n_out(oe_n_out),
    .ce_n_out(ce_n_out)
  );

  assign req_ready_out = (st_reg == FCMI_ST_IDLE);
  assign rsp_valid_out = (st_reg == FCMI_ST_RESP);
  assign rsp_data_out = rsp_reg;
  assign rsp_busy_out = !ready_in;
  assign mode_out = mode_reg;
  assign mode_bank_out = bank_reg;
  assign area_locked_out = locked_reg;

  // command writes keep the upper byte at zero
  a_upper_byte_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (bus.start && bus.wr && step_reg != 3'h3) |-> bus.wdata[15:8] == 8'h00)
    else $error("command write with nonzero upper byte");
  // erase code only as the sixth write
  a_erase_six_writes: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_reg == FCMI_ST_ISSUE && op_reg == FCMI_OP_ERASE && step_reg == 3'h5) |->
    bus.wdata[7:0] == sub_reg) else $error("erase code not on sixth write");
  // a locked area never leaves idle for a program
  a_locked_refuse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_reg == FCMI_ST_IDLE && req_valid_in && locked_reg &&
     req_op_in == FCMI_OP_AREA_PROG) |=> st_reg == FCMI_ST_RESP)
    else $error("program sent to locked area");
  // first write of a program is the first unlock word
  a_unlock_first: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_reg == FCMI_ST_ISSUE && op_reg == FCMI_OP_PROG && step_reg == 3'h0) |->
    bus.wdata[7:0] == FCMI_UNLOCK_D1) else $error("program without unlock");
  // exit while flash busy is answered as refused
  a_exit_refused: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st_reg == FCMI_ST_IDLE && req_valid_in && !ready_in &&
     req_op_in == FCMI_OP_EXIT) |=> (st_reg == FCMI_ST_RESP && rsp_reg == 16'hFFFF))
    else $error("exit sent while flash busy");
endmodule

/* rtl/fcmi_pkg.sv */
// package: command codes, bus timing counts and modes of the flash command host
package fcmi_pkg;
  localparam int FCMI_ADDR_W = 21;
  localparam int FCMI_DATA_W = 16;
  localparam int FCMI_BANK_LSB = 18;
  localparam logic [FCMI_ADDR_W-1:0] FCMI_UNLOCK_A1 = 21'h000555;
  localparam logic [FCMI_ADDR_W-1:0] FCMI_UNLOCK_A2 = 21'h0002AA;
  localparam logic [FCMI_ADDR_W-1:0] FCMI_QUERY_SHORT_A = 21'h000055;
  localparam logic [7:0] FCMI_UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] FCMI_UNLOCK_D2 = 8'h55;
  localparam logic [7:0] FCMI_CMD_PROG = 8'hA0;
  localparam logic [7:0] FCMI_CMD_ERASE = 8'h80;
  localparam logic [7:0] FCMI_CMD_ERASE_SECT = 8'h50;
  localparam logic [7:0] FCMI_CMD_ERASE_BLOCK = 8'h30;
  localparam logic [7:0] FCMI_CMD_ERASE_CHIP = 8'h10;
  localparam logic [7:0] FCMI_CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] FCMI_CMD_QUERY = 8'h98;
  localparam logic [7:0] FCMI_CMD_AREA_QUERY = 8'h88;
  localparam logic [7:0] FCMI_CMD_AREA_PROG = 8'hA5;
  localparam logic [7:0] FCMI_CMD_AREA_LOCK = 8'h85;
  localparam logic [7:0] FCMI_CMD_EXIT = 8'hF0;
  localparam logic [7:0] FCMI_TOGGLE_BIT = 8'h06;
  // bus phase times in ns and cycles at 25 MHz (least times round up)
  localparam int FCMI_CLK_NS = 40;
  localparam int FCMI_T_WP_NS = 40;
  localparam int FCMI_READ_CYCLE_NS = 70;
  localparam int FCMI_WP_CYC = (FCMI_T_WP_NS + FCMI_CLK_NS - 1) / FCMI_CLK_NS;
  localparam int FCMI_RC_CYC = (FCMI_READ_CYCLE_NS + FCMI_CLK_NS - 1) / FCMI_CLK_NS;
  localparam int FCMI_CNT_W = 4;
  typedef enum logic [2:0] {
    FCMI_OP_READ = 3'h0,
    FCMI_OP_PROG = 3'h1,
    FCMI_OP_ERASE = 3'h2,
    FCMI_OP_ID = 3'h3,
    FCMI_OP_QUERY = 3'h4,
    FCMI_OP_AREA = 3'h5,
    FCMI_OP_AREA_PROG = 3'h6,
    FCMI_OP_EXIT = 3'h7
  } fcmi_op_t;
  typedef enum logic [2:0] {
    FCMI_MODE_ARRAY = 3'h0,
    FCMI_MODE_ID = 3'h1,
    FCMI_MODE_QUERY = 3'h2,
    FCMI_MODE_AREA = 3'h3,
    FCMI_MODE_LOCKED = 3'h4
  } fcmi_mode_t;
endpackage

/* sim/fcmi_flash_model.sv */
// behavioural model of the eight-bank flash that the command host drives
`timescale 1ns/1ps
module fcmi_flash_model
  import fcmi_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00A1, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0B2C, // arbitrary value
  parameter logic [15:0] QUERY_WORD = 16'h0051,
  parameter int BUSY_NS = 400
)(
  input wire logic [FCMI_ADDR_W-1:0] addr_in,
  input wire logic [FCMI_DATA_W-1:0] dq_in,
  output logic [FCMI_DATA_W-1:0] dq_out,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic ce_n_in,
  input wire logic busy_hold_in,
  output logic ready_out
);
  // ****************************************
  // command decode and array state
  // ****************************************
  logic [15:0] mem [16];
  logic [15:0] area [16];
  logic [15:0] rd;
  logic [15:0] last;
  logic [2:0] st;
  logic [2:0] mbank;
  logic [2:0] bbank;
  logic [7:0] cd;
  logic [17:0] la;
  logic locked, busy, tog, hi_err;
  fcmi_mode_t mode;
  int wr_cnt;

  // id area: 8 preset factory words, user words blank
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'hFFFF;
      area[i] = (i < 8) ? 16'h00C0 + i : 16'hFFFF;
    end
    st = 3'h0;
    mode = FCMI_MODE_ARRAY;
    {mbank, bbank, locked, busy, tog, hi_err, wr_cnt, last} = '0;
  end

  // toggling bit alternates for every status read while busy
  always @(negedge oe_n_in) begin
    if (busy) begin
      tog = ~tog;
    end
  end

  assign ready_out = !(busy || busy_hold_in);

  task automatic set_mode(input fcmi_mode_t m);
    mode = m;
    mbank = addr_in[20:18];
  endtask

  task automatic go_busy();
    busy = 1'b1;
    bbank = addr_in[20:18];
    busy <= #(BUSY_NS) 1'b0;
  endtask

  // upper-byte guard is off for data writes and only the low byte is compared
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      wr_cnt++;
      cd = dq_in[7:0];
      la = addr_in[17:0];
      if (st != 3'h3 && st != 3'h7 && dq_in[15:8] != 8'h00) begin
        hi_err = 1'b1;
      end
      // exit recovers to array read unless an operation runs
      if (cd == FCMI_CMD_EXIT && st != 3'h3 && st != 3'h7) begin
        if (!busy) begin
          mode = FCMI_MODE_ARRAY;
        end
        st = 3'h0;
      end else begin
        case (st)
          3'h0: begin
            if (la == 18'h555 && cd == FCMI_UNLOCK_D1) st = 3'h1;
            else if (la == 18'h55 && cd == FCMI_CMD_QUERY) set_mode(FCMI_MODE_QUERY);
          end
          3'h1: st = (la == 18'h2AA && cd == FCMI_UNLOCK_D2) ? 3'h2 : 3'h0;
          3'h2: begin
            st = 3'h0;
            if (la != 18'h555) mode = FCMI_MODE_ARRAY;
            else if (cd == FCMI_CMD_PROG) st = 3'h3;
            else if (cd == FCMI_CMD_ERASE) st = 3'h4;
            else if (cd == FCMI_CMD_ID_ENTRY) set_mode(FCMI_MODE_ID);
            else if (cd == FCMI_CMD_QUERY) set_mode(FCMI_MODE_QUERY);
            else if (cd == FCMI_CMD_AREA_QUERY) set_mode(FCMI_MODE_AREA);
            else if (cd == FCMI_CMD_AREA_PROG) st = 3'h7;
            else if (cd == FCMI_CMD_AREA_LOCK) locked = 1'b1;
            else mode = FCMI_MODE_ARRAY;
          end
          // array program never reaches the id area
          3'h3: begin
            mem[addr_in[3:0]] = dq_in;
            st = 3'h0;
            go_busy();
          end
          3'h4: st = (la == 18'h555 && cd == FCMI_UNLOCK_D1) ? 3'h5 : 3'h0;
          3'h5: st = (la == 18'h2AA && cd == FCMI_UNLOCK_D2) ? 3'h6 : 3'h0;
          // erase clears the array only, never the id area
          3'h6: begin
            st = 3'h0;
            if (cd == FCMI_CMD_ERASE_SECT || cd == FCMI_CMD_ERASE_BLOCK ||
                cd == FCMI_CMD_ERASE_CHIP) begin
              for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
              go_busy();
            end
          end
          default: begin
            st = 3'h0;
            if (!locked && addr_in[3]) area[addr_in[3:0]] = dq_in;
            go_busy();
          end
        endcase
      end
    end
  end

  // mode reads hit the chosen bank only
  always @* begin
    if (!ce_n_in && !oe_n_in) begin
      if (busy && addr_in[20:18] == bbank) rd = {9'h000, tog, 6'h00};
      else if (mode == FCMI_MODE_ID && addr_in[20:18] == mbank)
        rd = (addr_in[17:0] == 18'h0) ? MAKER_CODE :
             (addr_in[17:0] == 18'h1) ? PART_CODE : 16'h0000;
      else if (mode == FCMI_MODE_QUERY && addr_in[20:18] == mbank) rd = QUERY_WORD;
      else if (mode == FCMI_MODE_AREA && addr_in[20:18] == mbank) rd = area[addr_in[3:0]];
      else rd = mem[addr_in[3:0]];
      last = rd;
      dq_out = rd;
    end else begin
      // released bus shows the inverse so a stale value never reads back
      dq_out = ~last;
    end
  end
endmodule

/* sim/fcmi_host_tb.sv */
// self-checking testbench of the flash command host against the flash model
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module fcmi_host_tb;
  import fcmi_pkg::*;
  localparam logic [15:0] MAKER = 16'h00A1; // arbitrary value
  localparam logic [15:0] PART = 16'h0B2C; // arbitrary value
  localparam logic [15:0] QWORD = 16'h0051;
  logic clk_sys_in, sys_rst_in, req_valid_in, hold;
  logic [2:0] req_op_in;
  logic [20:0] req_addr_in, addr_out;
  logic [15:0] req_data_in, rsp_data_out, dq_out, flash_dq, dq_wire, r;
  logic [7:0] req_sub_in;
  logic req_ready_out, rsp_valid_out, rsp_busy_out, area_locked_out;
  logic dq_oe_out, we_n_out, oe_n_out, ce_n_out, ready_in;
  logic [2:0] mode_out, mode_bank_out;
  int fail_count, num_checks, wd;

  assign dq_wire = dq_oe_out ? dq_out : flash_dq;

  fcmi_host i_fcmi_host (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_op_in(req_op_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .req_sub_in(req_sub_in),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .rsp_busy_out(rsp_busy_out),
    .mode_out(mode_out), .mode_bank_out(mode_bank_out), .area_locked_out(area_locked_out),
    .addr_out(addr_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dq_in(dq_wire),
    .we_n_out(we_n_out), .oe_n_out(oe_n_out), .ce_n_out(ce_n_out), .ready_in(ready_in));

  fcmi_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .QUERY_WORD(QWORD))
    i_fcmi_flash_model (.addr_in(addr_out), .dq_in(dq_wire), .dq_out(flash_dq),
    .we_n_in(we_n_out), .oe_n_in(oe_n_out), .ce_n_in(ce_n_out),
    .busy_hold_in(hold), .ready_out(ready_in));

  // ****************************************
  // request driver and scenarios
  // ****************************************
  task automatic issue(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d,
                       input logic [7:0] s);
    int n;
    int w0;
    w0 = i_fcmi_flash_model.wr_cnt;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    req_valid_in = 1'b1;
    req_op_in = op;
    req_addr_in = a;
    req_data_in = d;
    req_sub_in = s;
    @(negedge clk_sys_in);
    req_valid_in = 1'b0;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 2000) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, n, 0);
    end
    r = rsp_data_out;
    wd = i_fcmi_flash_model.wr_cnt - w0;
    @(negedge clk_sys_in);
  endtask

  task automatic t_prog();
    issue(FCMI_OP_PROG, 21'h000003, 16'h1234, 8'h00);
    `CHK(wd, 4)
    issue(FCMI_OP_READ, 21'h000003, 16'h0000, 8'h00);
    `CHK(r, 16'h1234)
    `CHK(i_fcmi_flash_model.hi_err, 1'b0)
  endtask

  task automatic t_id();
    issue(FCMI_OP_ID, 21'h040000, 16'h0000, 8'h00);
    `CHK(mode_out, 3'h1)
    `CHK(mode_bank_out, 3'h1)
    issue(FCMI_OP_READ, 21'h040000, 16'h0000, 8'h00);
    `CHK(r, MAKER)
    issue(FCMI_OP_READ, 21'h040001, 16'h0000, 8'h00);
    `CHK(r, PART)
    issue(FCMI_OP_READ, 21'h000003, 16'h0000, 8'h00);
    `CHK(r, 16'h1234)
    hold = 1'b1;
    @(negedge clk_sys_in);
    `CHK(rsp_busy_out, 1'b1)
    issue(FCMI_OP_EXIT, 21'h040000, 16'h0000, 8'h00);
    `CHK(r, 16'hFFFF)
    `CHK(wd, 0)
    `CHK(mode_out, 3'h1)
    hold = 1'b0;
    @(negedge clk_sys_in);
    issue(FCMI_OP_EXIT, 21'h040000, 16'h0000, 8'h00);
    `CHK(mode_out, 3'h0)
    issue(FCMI_OP_READ, 21'h040003, 16'h0000, 8'h00);
    `CHK(r, 16'h1234)
  endtask

  task automatic t_query();
    issue(FCMI_OP_QUERY, 21'h080000, 16'h0000, FCMI_CMD_QUERY);
    `CHK(wd, 1)
    `CHK(mode_out, 3'h2)
    repeat (2) begin
      issue(FCMI_OP_READ, 21'h080010, 16'h0000, 8'h00);
      `CHK(r, QWORD)
    end
    issue(FCMI_OP_EXIT, 21'h080000, 16'h0000, 8'h00);
    `CHK(mode_out, 3'h0)
    issue(FCMI_OP_QUERY, 21'h080000, 16'h0000, 8'h00);
    `CHK(wd, 3)
    `CHK(mode_out, 3'h2)
    issue(FCMI_OP_EXIT, 21'h080000, 16'h0000, 8'h00);
    `CHK(mode_out, 3'h0)
  endtask

  task automatic area_read(input logic [20:0] a, input logic [15:0] e);
    issue(FCMI_OP_AREA, 21'h000000, 16'h0000, 8'h00);
    `CHK(mode_out, 3'h3)
    issue(FCMI_OP_READ, a, 16'h0000, 8'h00);
    `CHK(r, e)
    issue(FCMI_OP_READ, 21'h000002, 16'h0000, 8'h00);
    `CHK(r, 16'h00C2)
    issue(FCMI_OP_EXIT, 21'h000000, 16'h0000, 8'h00);
    `CHK(mode_out, 3'h0)
  endtask

  task automatic t_area();
    issue(FCMI_OP_AREA_PROG, 21'h000009, 16'h5A5A, 8'h00);
    issue(FCMI_OP_AREA_PROG, 21'h000002, 16'h0000, 8'h00);
    area_read(21'h000009, 16'h5A5A);
    issue(FCMI_OP_AREA_PROG, 21'h000000, 16'h0000, FCMI_CMD_AREA_LOCK);
    `CHK(area_locked_out, 1'b1)
    issue(FCMI_OP_AREA_PROG, 21'h00000A, 16'h1111, 8'h00);
    `CHK(r, 16'hFFFF)
    `CHK(wd, 0)
  endtask

  task automatic t_erase();
    logic [7:0] codes [3];
    codes = '{FCMI_CMD_ERASE_SECT, FCMI_CMD_ERASE_BLOCK, FCMI_CMD_ERASE_CHIP};
    foreach (codes[i]) begin
      issue(FCMI_OP_PROG, 21'h000003, 16'h00A5, 8'h00);
      issue(FCMI_OP_ERASE, 21'h000003, 16'h0000, codes[i]);
      `CHK(wd, 6)
      issue(FCMI_OP_READ, 21'h000003, 16'h0000, 8'h00);
      `CHK(r, 16'hFFFF)
    end
    area_read(21'h000009, 16'h5A5A);
  endtask

  task complete_run();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #(40 * 50000);
    fail_count++;
    complete_run();
  end

  initial begin
    {req_valid_in, hold, req_op_in, req_addr_in, req_data_in, req_sub_in} = '0;
    fail_count = 0;
    num_checks = 0;
    sys_rst_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    @(negedge clk_sys_in);
    `CHK({we_n_out, oe_n_out, ce_n_out, dq_oe_out}, 4'hE)
    `CHK(mode_out, 3'h0)
    t_prog();
    t_id();
    t_query();
    t_area();
    t_erase();
    complete_run();
  end
endmodule
